/* include/zdl_pkg.sv */
// constants, register map and types of the zero-crossing dependency logic
// assumes a 20 MHz clock and a 4 kHz sample strobe from the datapath
package zdl_pkg;
   // channel layout: 0-2 current, 3-5 voltage, 6-11 auxiliary, 12 combined
   localparam int NCH = 13;
   localparam int NRAW = 12;
   localparam int CH_VA = 3;
   localparam int CH_COMB = 12;
   localparam int NV = 3;
   // status layout
   localparam int NST = 20;
   localparam int ST_TO = 16;
   localparam int ST_SEQ = 19;
   localparam int NEV = 26;
   // register byte offsets
   localparam logic [7:0] A_STATUS = 8'h00;
   localparam logic [7:0] A_CLEAR = 8'h04;
   localparam logic [7:0] A_ENABLE = 8'h08;
   localparam logic [7:0] A_CONFIG = 8'h0C;
   localparam logic [7:0] A_TOUT = 8'h10;
   localparam logic [7:0] A_HMODE = 8'h14;
   localparam logic [7:0] A_UHALF = 8'h18;
   localparam logic [7:0] A_EV_ONE = 8'h1C;
   localparam logic [7:0] A_EV_HALF = 8'h20;
   localparam logic [7:0] A_PERIOD_A = 8'h24;
   localparam logic [7:0] A_PERIOD_B = 8'h28;
   localparam logic [7:0] A_PERIOD_C = 8'h2C;
   localparam logic [7:0] A_ANGLE_0 = 8'h30;
   localparam logic [7:0] A_ANGLE_1 = 8'h34;
   localparam logic [7:0] A_ANGLE_2 = 8'h38;
   localparam logic [7:0] A_ONEWIN = 8'h3C;
   // config fields
   localparam int CFG_W = 5;
   localparam int CF_SRC = 0;
   localparam int CF_LP = 2;
   localparam int CF_FREQ = 4;
   // coerced periods
   localparam logic [31:0] PERIOD_50 = 32'h0050_0000;
   localparam logic [31:0] PERIOD_60 = 32'h0042_AAAA;
   // timing
   localparam int CLK_HZ = 20_000_000;
   localparam int MS_PER_S = 1000;
   localparam int HOLDOFF_MS = 1;
   localparam int SAMPLE_HZ = 4000;
   localparam int FMIN_HZ = 40;
   localparam int FMAX_HZ = 70;
   localparam logic [7:0] PER_MAX = 8'(SAMPLE_HZ / FMIN_HZ);
   localparam logic [7:0] PER_MIN = 8'((SAMPLE_HZ + FMAX_HZ - 1) / FMAX_HZ);
   localparam logic [7:0] PER_SAT = 8'hFF;
   localparam logic [15:0] CNT_SAT = 16'hFFFF;
   // angle pairs: first and second channel
   localparam int ANG_P [0:2] = '{3, 3, 3};
   localparam int ANG_S [0:2] = '{4, 5, 0};
   // phase-sequence tracker
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_WAIT_A, SEQ_WAIT_B, SEQ_WAIT_C} zdl_seq_t;
endpackage

/* include/zdl_chan_if.sv */
// one channel's raw and qualified crossing events
// assumes a single clock domain shared by both ends
`timescale 1ns/10ps
`default_nettype none
interface zdl_chan_if;
   logic rise_raw;
   logic fall_raw;
   logic rise;
   logic fall;
   modport main (output rise_raw, output fall_raw, input rise, input fall);
   modport qual (input rise_raw, input fall_raw, output rise, output fall);
endinterface
`default_nettype wire

/* hdl/zdl_qual.sv */
// crossing qualifier: passes one crossing, then holds off the channel
// assumes raw events are one-cycle pulses synchronous to clock
`timescale 1ns/10ps
`default_nettype none
module zdl_qual #(
   parameter int HOLD_CYCLES = 20000
) (
   input wire logic clock,
   input wire logic rst,
   zdl_chan_if.qual ch
);
   typedef struct packed {
      logic [15:0] cnt;
      logic rise;
      logic fall;
   } zdl_qual_t;

   zdl_qual_t s_r;
   zdl_qual_t s_nxt;

   // holdoff counter, rise wins on a double event
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.rise = 1'b0;
      s_nxt.fall = 1'b0;
      if (s_r.cnt != 16'h0000)
      begin
         s_nxt.cnt = s_r.cnt - 16'h0001;
      end
      else if (ch.rise_raw || ch.fall_raw)
      begin
         s_nxt.rise = ch.rise_raw;
         s_nxt.fall = !ch.rise_raw;
         s_nxt.cnt = 16'(HOLD_CYCLES - 1);
      end
   end

   // state register
   always_ff @(posedge clock)
   begin
      if (rst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign ch.rise = s_r.rise;
   assign ch.fall = s_r.fall;
endmodule // zdl_qual
`default_nettype wire

/* hdl/zdl_top.sv */
// zero-crossing dependency logic with an APB register slave
// assumes APB from a master on clock; sample_strobe marks 4 kHz samples
// Behaviour
// - flag per channel on both crossing edges
// - flag sticky; stays clear without crossings
// - per-phase timeout flag, both edges, maskable
// - sequence error from rising voltage crossings only
// - no sequence error when all phases missing
// - two-bit select picks line-cycle crossing source
// - no selected crossings, no line-cycle update
// - rising-edge period, coerced to 50/60 Hz default
// - one-cycle window from selected phase period
// - invalid or out-of-band period uses default
// - half-cycle mode bit uses user half period
// - crossing mode: no crossing, no half update
// - angles on rising crossings; hold otherwise
// - timeout after limit plus one milliseconds
// - 1 ms holdoff after each channel crossing
// - combined signal is A + B - C
// - one-cycle and half-cycle events separate registers
`timescale 1ns/10ps
`default_nettype none
module zdl_top #(
   parameter int MS_CYCLES = zdl_pkg::CLK_HZ / zdl_pkg::MS_PER_S,
   parameter int HOLD_CYCLES = zdl_pkg::HOLDOFF_MS * MS_CYCLES
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic sample_strobe,
   input wire logic [23:0] volt_a,
   input wire logic [23:0] volt_b,
   input wire logic [23:0] volt_c,
   input wire logic [11:0] cross_rise_raw,
   input wire logic [11:0] cross_fall_raw,
   input wire logic [25:0] one_event,
   input wire logic [25:0] half_event,
   output logic line_cycle_tick,
   output logic cross_out,
   output logic [12:0] half_update,
   output logic [31:0] one_cycle_period
);
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic irq;
      logic [19:0] status;
      logic [19:0] enable;
      logic [4:0] cfg;
      logic [15:0] tout_limit;
      logic [12:0] half_mode;
      logic [31:0] user_half;
      logic [25:0] ev_one;
      logic [25:0] ev_half;
      logic [15:0] ms_cnt;
      logic ms_tick;
      logic [2:0][15:0] tout_cnt;
      logic [2:0][7:0] per_cnt;
      logic [2:0] per_seen;
      logic [2:0][31:0] period;
      logic [31:0] one_win;
      logic [2:0][15:0] ang_cnt;
      logic [2:0][31:0] angle;
      logic [12:0][15:0] half_cnt;
      logic [12:0] half_upd;
      zdl_pkg::zdl_seq_t seq;
      logic comb_neg;
      logic comb_seen;
      logic line_tick;
      logic cross_out;
   } zdl_state_t;

   zdl_state_t s_r;
   zdl_state_t s_nxt;
   logic [12:0] raw_rise;
   logic [12:0] raw_fall;
   logic [12:0] q_rise;
   logic [12:0] q_fall;
   logic [12:0] ev_any;
   logic [25:0] comb_sum;
   logic comb_rise;
   logic comb_fall;
   logic wr;
   logic [31:0] rd_data;
   logic rd_hit;
   logic [2:0] vrise;
   logic [1:0] ph;
   logic seq_ok;
   logic [31:0] def_period;
   logic [1:0] src;
   logic [1:0] lp;

   // combined voltage sign tracking on each sample
   assign comb_sum = {{2{volt_a[23]}}, volt_a} + {{2{volt_b[23]}}, volt_b}
                     - {{2{volt_c[23]}}, volt_c};
   assign comb_rise = sample_strobe && s_r.comb_seen && s_r.comb_neg && !comb_sum[25];
   assign comb_fall = sample_strobe && s_r.comb_seen && !s_r.comb_neg && comb_sum[25];
   assign raw_rise = {comb_rise, cross_rise_raw};
   assign raw_fall = {comb_fall, cross_fall_raw};
   assign ev_any = q_rise | q_fall;
   assign vrise = q_rise[zdl_pkg::CH_VA +: zdl_pkg::NV];
   assign wr = psel && penable && s_r.pready && pwrite;
   assign def_period = s_r.cfg[zdl_pkg::CF_FREQ] ? zdl_pkg::PERIOD_60 : zdl_pkg::PERIOD_50;
   assign src = s_r.cfg[zdl_pkg::CF_SRC +: 2];
   assign lp = s_r.cfg[zdl_pkg::CF_LP +: 2];

   // per-channel crossing qualifiers
   for (genvar i = 0; i < zdl_pkg::NCH; i++)
   begin : g_ch
      zdl_chan_if ch ();
      assign ch.rise_raw = raw_rise[i];
      assign ch.fall_raw = raw_fall[i];
      assign q_rise[i] = ch.rise;
      assign q_fall[i] = ch.fall;
      zdl_qual #(.HOLD_CYCLES(HOLD_CYCLES)) u_qual (
         .clock(clock),
         .rst(rst),
         .ch(ch.qual)
      );
   end

   // register read decode
   always_comb
   begin
      rd_hit = 1'b1;
      rd_data = '0;
      if (paddr == zdl_pkg::A_STATUS)
         rd_data = {{(32 - zdl_pkg::NST){1'b0}}, s_r.status};
      else if (paddr == zdl_pkg::A_CLEAR)
         rd_data = '0;
      else if (paddr == zdl_pkg::A_ENABLE)
         rd_data = {{(32 - zdl_pkg::NST){1'b0}}, s_r.enable};
      else if (paddr == zdl_pkg::A_CONFIG)
         rd_data = {{(32 - zdl_pkg::CFG_W){1'b0}}, s_r.cfg};
      else if (paddr == zdl_pkg::A_TOUT)
         rd_data = {16'h0000, s_r.tout_limit};
      else if (paddr == zdl_pkg::A_HMODE)
         rd_data = {19'h00000, s_r.half_mode};
      else if (paddr == zdl_pkg::A_UHALF)
         rd_data = s_r.user_half;
      else if (paddr == zdl_pkg::A_EV_ONE)
         rd_data = {6'h00, s_r.ev_one};
      else if (paddr == zdl_pkg::A_EV_HALF)
         rd_data = {6'h00, s_r.ev_half};
      else if (paddr == zdl_pkg::A_PERIOD_A)
         rd_data = s_r.period[0];
      else if (paddr == zdl_pkg::A_PERIOD_B)
         rd_data = s_r.period[1];
      else if (paddr == zdl_pkg::A_PERIOD_C)
         rd_data = s_r.period[2];
      else if (paddr == zdl_pkg::A_ANGLE_0)
         rd_data = s_r.angle[0];
      else if (paddr == zdl_pkg::A_ANGLE_1)
         rd_data = s_r.angle[1];
      else if (paddr == zdl_pkg::A_ANGLE_2)
         rd_data = s_r.angle[2];
      else if (paddr == zdl_pkg::A_ONEWIN)
         rd_data = s_r.one_win;
      else
         rd_hit = 1'b0;
   end

   // phase-sequence check on rising voltage crossings
   always_comb
   begin
      ph = vrise[0] ? 2'd0 : (vrise[1] ? 2'd1 : 2'd2);
      case (s_r.seq)
         zdl_pkg::SEQ_WAIT_A: seq_ok = (ph == 2'd0);
         zdl_pkg::SEQ_WAIT_B: seq_ok = (ph == 2'd1);
         zdl_pkg::SEQ_WAIT_C: seq_ok = (ph == 2'd2);
         default: seq_ok = 1'b1;
      endcase
   end

   // next state of the whole block
   always_comb
   begin
      s_nxt = s_r;
      // apb: answer prepared in setup, zero wait states
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
      if (psel && !penable)
      begin
         s_nxt.pready = 1'b1;
         s_nxt.prdata = rd_data;
         s_nxt.pslverr = !rd_hit;
      end
      if (wr && paddr == zdl_pkg::A_ENABLE)
         s_nxt.enable = pwdata[zdl_pkg::NST-1:0];
      if (wr && paddr == zdl_pkg::A_CONFIG)
         s_nxt.cfg = pwdata[zdl_pkg::CFG_W-1:0];
      if (wr && paddr == zdl_pkg::A_TOUT)
         s_nxt.tout_limit = pwdata[15:0];
      if (wr && paddr == zdl_pkg::A_HMODE)
         s_nxt.half_mode = pwdata[12:0];
      if (wr && paddr == zdl_pkg::A_UHALF)
         s_nxt.user_half = pwdata;
      // clears first so a same-cycle event still sets
      if (wr && paddr == zdl_pkg::A_CLEAR)
         s_nxt.status = s_r.status & ~pwdata[zdl_pkg::NST-1:0];
      if (wr && paddr == zdl_pkg::A_EV_ONE)
         s_nxt.ev_one = s_r.ev_one & ~pwdata[zdl_pkg::NEV-1:0];
      if (wr && paddr == zdl_pkg::A_EV_HALF)
         s_nxt.ev_half = s_r.ev_half & ~pwdata[zdl_pkg::NEV-1:0];
      // crossing flags set only by crossings
      s_nxt.status[zdl_pkg::NCH-1:0] = s_nxt.status[zdl_pkg::NCH-1:0] | ev_any;
      // dip and swell events from the rms stages
      s_nxt.ev_one = s_nxt.ev_one | one_event;
      s_nxt.ev_half = s_nxt.ev_half | (half_event & {s_r.half_upd, s_r.half_upd});
      // millisecond tick
      s_nxt.ms_tick = 1'b0;
      if (s_r.ms_cnt == 16'(MS_CYCLES - 1))
      begin
         s_nxt.ms_cnt = 16'h0000;
         s_nxt.ms_tick = 1'b1;
      end
      else
         s_nxt.ms_cnt = s_r.ms_cnt + 16'h0001;
      // comb sign history
      if (sample_strobe)
      begin
         s_nxt.comb_neg = comb_sum[25];
         s_nxt.comb_seen = 1'b1;
      end
      // per voltage phase: timeout and line period
      for (int k = 0; k < zdl_pkg::NV; k++)
      begin
         if (ev_any[zdl_pkg::CH_VA + k])
            s_nxt.tout_cnt[k] = 16'h0000;
         else if (s_r.ms_tick && s_r.tout_cnt[k] != zdl_pkg::CNT_SAT)
         begin
            s_nxt.tout_cnt[k] = s_r.tout_cnt[k] + 16'h0001;
            if (s_r.tout_cnt[k] == s_r.tout_limit)
               s_nxt.status[zdl_pkg::ST_TO + k] = 1'b1;
         end
         if (q_rise[zdl_pkg::CH_VA + k])
         begin
            s_nxt.per_cnt[k] = 8'h00;
            s_nxt.per_seen[k] = 1'b1;
            if (s_r.per_seen[k] && s_r.per_cnt[k] >= zdl_pkg::PER_MIN
                && s_r.per_cnt[k] <= zdl_pkg::PER_MAX)
               s_nxt.period[k] = {8'h00, s_r.per_cnt[k], 16'h0000} - 32'h0000_0001;
            else
               s_nxt.period[k] = def_period;
         end
         else
         begin
            if (sample_strobe && s_r.per_cnt[k] != zdl_pkg::PER_SAT)
               s_nxt.per_cnt[k] = s_r.per_cnt[k] + 8'h01;
            if (!s_r.per_seen[k] || s_r.per_cnt[k] > zdl_pkg::PER_MAX)
               s_nxt.period[k] = def_period;
         end
      end
      // sequence error, none when no rising crossing arrives
      if (|vrise)
      begin
         if (!seq_ok)
            s_nxt.status[zdl_pkg::ST_SEQ] = 1'b1;
         case (ph)
            2'd0: s_nxt.seq = zdl_pkg::SEQ_WAIT_B;
            2'd1: s_nxt.seq = zdl_pkg::SEQ_WAIT_C;
            default: s_nxt.seq = zdl_pkg::SEQ_WAIT_A;
         endcase
      end
      // angles between rising crossings of a pair
      for (int j = 0; j < 3; j++)
      begin
         if (q_rise[zdl_pkg::ANG_P[j]])
            s_nxt.ang_cnt[j] = 16'h0000;
         else if (sample_strobe && s_r.ang_cnt[j] != zdl_pkg::CNT_SAT)
            s_nxt.ang_cnt[j] = s_r.ang_cnt[j] + 16'h0001;
         if (q_rise[zdl_pkg::ANG_S[j]])
            s_nxt.angle[j] = {8'h00, s_r.ang_cnt[j], 8'h00};
      end
      // half-cycle update strobes per channel
      for (int c = 0; c < zdl_pkg::NCH; c++)
      begin
         s_nxt.half_upd[c] = 1'b0;
         if (s_r.half_mode[c])
         begin
            if (sample_strobe)
            begin
               if (s_r.half_cnt[c] + 16'h0001 >= s_r.user_half[31:16])
               begin
                  s_nxt.half_cnt[c] = 16'h0000;
                  s_nxt.half_upd[c] = 1'b1;
               end
               else
                  s_nxt.half_cnt[c] = s_r.half_cnt[c] + 16'h0001;
            end
         end
         else
         begin
            s_nxt.half_cnt[c] = 16'h0000;
            s_nxt.half_upd[c] = ev_any[c];
         end
      end
      // one-cycle window from the selected phase period
      if (lp < 2'd3)
         s_nxt.one_win = s_r.period[lp];
      else
         s_nxt.one_win = s_r.period[0];
      // line-cycle source, both edges
      if (src == 2'd3)
         s_nxt.line_tick = ev_any[zdl_pkg::CH_COMB];
      else
         s_nxt.line_tick = ev_any[zdl_pkg::CH_VA + 32'(src)];
      s_nxt.cross_out = s_r.cross_out ^ s_nxt.line_tick;
      // interrupt
      s_nxt.irq = |(s_nxt.status & s_nxt.enable);
   end

   // state register
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         s_r <= '0;
         s_r.period <= {zdl_pkg::NV{zdl_pkg::PERIOD_50}};
         s_r.one_win <= zdl_pkg::PERIOD_50;
      end
      else
         s_r <= s_nxt;
   end

   // outputs straight from state
   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign irq = s_r.irq;
   assign line_cycle_tick = s_r.line_tick;
   assign cross_out = s_r.cross_out;
   assign half_update = s_r.half_upd;
   assign one_cycle_period = s_r.one_win;
endmodule // zdl_top
`default_nettype wire

/* tb/zdl_top_assertions.sv */
// checker of zdl_top port timing
// assumes one clock domain; bound into every zdl_top
`timescale 1ns/10ps
`default_nettype none
module zdl_top_assertions (
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic irq,
   input wire logic line_cycle_tick,
   input wire logic cross_out,
   input wire logic [12:0] half_update,
   input wire logic [31:0] one_cycle_period
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // apb phases
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_wr;
      psel && penable && pwrite;
   endsequence
   // bus answer
   AST_ANSWER: assert property (s_setup |=> pready)
      else $error("pready missing after setup");
   AST_READY_ACCESS: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   AST_ERR_DATA: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
      else $error("error answer with data");
   // irq drops only after a register write
   AST_IRQ_FALL: assert property ($fell(irq) |-> $past(psel && penable && pwrite, 1))
      else $error("irq dropped without write");
   // line-cycle crossing output
   AST_TICK_PULSE: assert property (line_cycle_tick |=> !line_cycle_tick)
      else $error("tick longer than one cycle");
   AST_CROSS_OUT: assert property (line_cycle_tick |-> ##[0:1] (cross_out != $past(cross_out)))
      else $error("cross output did not toggle");
   AST_HOLDOFF: assert property (half_update[3] |=> !half_update[3] [*8])
      else $error("crossing inside holdoff");
   AST_PERIOD_RESET: assert property ($fell(rst) |-> one_cycle_period == 32'h0050_0000)
      else $error("period not default after reset");
endmodule // zdl_top_assertions
bind zdl_top zdl_top_assertions u_chk (.clock, .rst, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
   .irq, .line_cycle_tick, .cross_out, .half_update, .one_cycle_period);
`default_nettype wire

/* tb/test_zero_crossing_dependency_logic.sv */
// self-checking bench of zdl_top over apb and raw crossing pulses
// assumes ms and holdoff counts shortened to 20 cycles
`timescale 1ns/10ps
`default_nettype none
module test_zero_crossing_dependency_logic;
   localparam int LIMIT = 20000;
   typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic err;} zdl_row_t;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic sample_strobe = 1'b0;
   logic [23:0] volt_a = 24'h000064;
   logic [23:0] volt_b = 24'h000064;
   logic [23:0] volt_c = 24'h00012C;
   logic [11:0] cross_rise_raw = 12'h000;
   logic [11:0] cross_fall_raw = 12'h000;
   logic [25:0] one_event = 26'h0;
   logic [25:0] half_event = 26'h0;
   logic line_cycle_tick;
   logic cross_out;
   logic [12:0] half_update;
   logic [31:0] one_cycle_period;
   logic [31:0] rd;
   logic er;
   int n_errors = 0;
   int cmp_count = 0;
   int n_tick = 0;
   int n_h0 = 0;
   int n_h3 = 0;
   int cyc = 0;
   int k;
   zdl_row_t rows [0:10] = '{
      '{1'b0, zdl_pkg::A_PERIOD_C, 32'h0, zdl_pkg::PERIOD_50, 1'b0},
      '{1'b1, zdl_pkg::A_CONFIG, 32'h10, 32'h0, 1'b0},
      '{1'b0, zdl_pkg::A_CONFIG, 32'h0, 32'h10, 1'b0},
      '{1'b0, zdl_pkg::A_PERIOD_A, 32'h0, zdl_pkg::PERIOD_60, 1'b0},
      '{1'b1, zdl_pkg::A_PERIOD_B, 32'h1234, 32'h0, 1'b0},
      '{1'b0, zdl_pkg::A_PERIOD_B, 32'h0, zdl_pkg::PERIOD_60, 1'b0},
      '{1'b1, zdl_pkg::A_TOUT, 32'h9, 32'h0, 1'b0},
      '{1'b0, zdl_pkg::A_TOUT, 32'h0, 32'h9, 1'b0},
      '{1'b1, 8'h40, 32'h5, 32'h0, 1'b1},
      '{1'b0, 8'h0E, 32'h0, 32'h0, 1'b1},
      '{1'b1, zdl_pkg::A_CONFIG, 32'h0, 32'h0, 1'b0}};

   zdl_top #(.MS_CYCLES(20), .HOLD_CYCLES(20)) dut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .irq, .sample_strobe, .volt_a, .volt_b, .volt_c, .cross_rise_raw,
      .cross_fall_raw, .one_event, .half_event, .line_cycle_tick, .cross_out, .half_update, .one_cycle_period);

   // clock
   initial
   begin
      forever #25 clock = ~clock;
   end

   // sample strobe every fourth cycle
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      sample_strobe <= (cyc[1:0] == 2'b11);
   end

   // output monitors and watchdog, on settled values
   always @(negedge clock)
   begin
      if (line_cycle_tick === 1'b1)
         n_tick <= n_tick + 1;
      if (half_update[0] === 1'b1)
         n_h0 <= n_h0 + 1;
      if (half_update[3] === 1'b1)
         n_h3 <= n_h3 + 1;
      if (cyc == LIMIT)
      begin
         n_errors = n_errors + 1;
         wrap_up();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one apb transfer and an idle cycle; entered just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      // answer taken at the edge where pready is sampled high
      while (pready !== 1'b1)
         @(posedge clock);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(rd & m, e);
   endtask

   // one-cycle raw crossing pulses, then a wait
   task automatic pulse(input logic [11:0] r, input logic [11:0] f, input int w);
      cross_rise_raw <= r;
      cross_fall_raw <= f;
      @(posedge clock);
      cross_rise_raw <= 12'h000;
      cross_fall_raw <= 12'h000;
      repeat (w) @(posedge clock);
   endtask

   // settled output at the next falling edge: 0 irq, 1 period, 2 period off the 50 Hz default
   task automatic at_neg(input int sel, input logic [31:0] e);
      @(negedge clock);
      if (sel == 0)
         check(32'(irq), e);
      else if (sel == 1)
         check(one_cycle_period, e);
      else
         check(32'(one_cycle_period !== zdl_pkg::PERIOD_50), e);
      @(posedge clock);
   endtask

   task automatic vstep(input logic [23:0] c);
      volt_c <= c;
      repeat (30) @(posedge clock);
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // main sequence
   initial
   begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      at_neg(0, 32'h0);
      at_neg(1, zdl_pkg::PERIOD_50);
      $display("test reset done");
      foreach (rows[i])
      begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         check(32'(er), 32'(rows[i].err));
         if (!rows[i].w)
            check(rd, rows[i].e);
      end
      $display("test register rows done");
      pulse(12'h000, 12'hFFF, 25);
      rdm(zdl_pkg::A_STATUS, 32'hFFF, 32'hFFF);
      apb(1'b1, zdl_pkg::A_CLEAR, 32'hFFFFF);
      pulse(12'hFFF, 12'h000, 25);
      rdm(zdl_pkg::A_STATUS, 32'hFFF, 32'hFFF);
      apb(1'b1, zdl_pkg::A_CLEAR, 32'hFFFFF);
      repeat (100) @(posedge clock);
      rdm(zdl_pkg::A_STATUS, 32'hFFF, 32'h0);
      apb(1'b1, zdl_pkg::A_ENABLE, 32'h8);
      pulse(12'h008, 12'h000, 4);
      at_neg(0, 32'h1);
      apb(1'b1, zdl_pkg::A_CLEAR, 32'h8);
      at_neg(0, 32'h0);
      $display("test flags done");
      pulse(12'h008, 12'h000, 1);
      apb(1'b1, zdl_pkg::A_CLEAR, 32'h70000);
      repeat (92) @(posedge clock);
      pulse(12'h000, 12'h008, 110);
      rdm(zdl_pkg::A_STATUS, 32'h10000, 32'h0);
      repeat (120) @(posedge clock);
      rdm(zdl_pkg::A_STATUS, 32'h10000, 32'h10000);
      apb(1'b1, zdl_pkg::A_ENABLE, 32'h10000);
      at_neg(0, 32'h1);
      apb(1'b1, zdl_pkg::A_ENABLE, 32'h0);
      at_neg(0, 32'h0);
      $display("test timeout done");
      for (int i = 0; i < 6; i++)
      begin
         pulse(12'(8 << (i % 3)), 12'h000, 25);
         if (i == 2)
            apb(1'b1, zdl_pkg::A_CLEAR, 32'h80000);
      end
      pulse(12'h000, 12'h008, 25);
      pulse(12'h000, 12'h020, 25);
      pulse(12'h000, 12'h010, 25);
      rdm(zdl_pkg::A_STATUS, 32'h80000, 32'h0);
      pulse(12'h008, 12'h000, 25);
      pulse(12'h020, 12'h000, 25);
      rdm(zdl_pkg::A_STATUS, 32'h80000, 32'h80000);
      apb(1'b1, zdl_pkg::A_CLEAR, 32'h80000);
      repeat (200) @(posedge clock);
      rdm(zdl_pkg::A_STATUS, 32'h80000, 32'h0);
      // angle from the last a-to-b rise pair, then held with no crossings
      apb(1'b0, zdl_pkg::A_ANGLE_0, 32'h0);
      k = rd;
      check(32'(rd != 32'h0), 32'h1);
      repeat (200) @(posedge clock);
      rdm(zdl_pkg::A_ANGLE_0, 32'hFFFF_FFFF, 32'(k));
      $display("test sequence done");
      for (int s = 0; s < 3; s++)
      begin
         apb(1'b1, zdl_pkg::A_CONFIG, 32'(s));
         k = n_tick;
         for (int c = 0; c < 3; c++)
            pulse(12'(8 << c), 12'h000, 25);
         pulse(12'h000, 12'(8 << s), 25);
         check(32'(n_tick - k), 32'h2);
      end
      apb(1'b1, zdl_pkg::A_CONFIG, 32'h3);
      vstep(24'h00012C);
      apb(1'b1, zdl_pkg::A_CLEAR, 32'h1000);
      k = n_tick;
      vstep(24'h000064);
      vstep(24'hFFFED4);
      check(32'(n_tick - k), 32'h1);
      rdm(zdl_pkg::A_STATUS, 32'h1000, 32'h1000);
      $display("test line cycle done");
      apb(1'b1, zdl_pkg::A_CONFIG, 32'h0);
      repeat (3) pulse(12'h008, 12'h000, 319);
      at_neg(2, 32'h1);
      apb(1'b1, zdl_pkg::A_CONFIG, 32'h4);
      repeat (2) @(posedge clock);
      at_neg(1, zdl_pkg::PERIOD_50);
      apb(1'b1, zdl_pkg::A_CONFIG, 32'h10);
      repeat (3) pulse(12'h008, 12'h000, 199);
      at_neg(1, zdl_pkg::PERIOD_60);
      $display("test period done");
      k = n_h3;
      pulse(12'h008, 12'h000, 25);
      check(32'(n_h3 - k), 32'h1);
      k = n_h3;
      half_event[3] <= 1'b1;
      one_event[3] <= 1'b1;
      @(posedge clock);
      one_event[3] <= 1'b0;
      repeat (200) @(posedge clock);
      half_event[3] <= 1'b0;
      check(32'(n_h3 - k), 32'h0);
      rdm(zdl_pkg::A_EV_HALF, 32'h8, 32'h0);
      rdm(zdl_pkg::A_EV_ONE, 32'h8, 32'h8);
      apb(1'b1, zdl_pkg::A_HMODE, 32'h1);
      apb(1'b1, zdl_pkg::A_UHALF, 32'h000A_0000);
      k = n_h0;
      half_event[0] <= 1'b1;
      repeat (200) @(posedge clock);
      half_event[0] <= 1'b0;
      check(32'(n_h0 - k >= 3), 32'h1);
      rdm(zdl_pkg::A_EV_HALF, 32'h1, 32'h1);
      $display("test half cycle done");
      wrap_up();
   end
endmodule // test_zero_crossing_dependency_logic
`default_nettype wire
